/* common/tz_pkg.sv */
// Constants shared by the eight-bit timer/counter and its prescaler.
package tz_pkg;

  // ------------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam int CNT_W = 8;
  localparam logic [ADDR_W-1:0] OFF_COUNT = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_OPTION = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 4'h8;
  localparam logic [ADDR_W-1:0] OFF_MASK = 4'hC;

  // ------------------------------------------------------------------
  // Option control fields
  // ------------------------------------------------------------------
  localparam int OPT_W = 6;
  localparam int OPT_CS = 0;
  localparam int OPT_SE = 1;
  localparam int OPT_BYP = 2;
  localparam int OPT_PS_LSB = 3;
  localparam int PS_W = 3;
  localparam logic [OPT_W-1:0] OPTION_RST = 6'h04;

  // ------------------------------------------------------------------
  // Status and mask fields
  // ------------------------------------------------------------------
  localparam int ST_OVF = 0;
  localparam logic [CNT_W-1:0] COUNT_RST = 8'h00;
  localparam logic [CNT_W-1:0] COUNT_MAX = 8'hFF;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam logic [1:0] WR_HOLD_CYC = 2'h2;

endpackage

/* common/tz_presc_if.sv */
// Tick path between the timer/counter control and its prescaler.
`timescale 1ns/1ps
interface tz_presc_if;
  logic tick_in;
  logic clear;
  logic bypass;
  logic [tz_pkg::PS_W-1:0] ratio_sel;
  logic tick_out;

  modport ctrl (
    output tick_in, clear, bypass, ratio_sel,
    input tick_out
  );
  modport presc (
    input tick_in, clear, bypass, ratio_sel,
    output tick_out
  );
endinterface

/* dv/tz_ext_src.sv */
// Far-side model: drives the external count pin and counts gate pulses.
`timescale 1ns/1ps
module tz_ext_src (
  input wire logic sys_clk_i,
  input wire logic gate_i,
  output logic ext_o
);
  int gate_cnt = 0;
  initial ext_o = 1'b0;
  // Each level is held two cycles so every edge is seen.
  task automatic toggle(input int n);
    repeat (n) begin
      repeat (2) @(posedge sys_clk_i);
      ext_o <= ~ext_o;
    end
  endtask
  always @(posedge sys_clk_i) begin
    if (gate_i === 1'b1) gate_cnt++;
  end
endmodule

/* dv/tz_timer_tb.sv */
// Self-checking testbench for the eight-bit timer/counter.
`timescale 1ns/1ps
module tz_timer_tb;
  import tz_pkg::*;
  logic sys_clk, arst_n, wr, rd, ext, gate, irq;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata, v;
  int n_errors = 0;
  int checks_done = 0;
  int i, k;
  logic [15:0] seed = 16'h6E1F;
  logic [7:0] n;
  tz_timer uut (.sys_clk_i(sys_clk), .arst_n_i(arst_n), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .external_count_input_i(ext), .second_timer_gate_o(gate),
    .irq_o(irq));
  tz_ext_src ext_m (.sys_clk_i(sys_clk), .gate_i(gate), .ext_o(ext));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic finish_test;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  initial begin
    #(25 * 20000);
    n_errors++;
    finish_test();
  end
  initial begin
    arst_n = 1'b0;
    {wr, rd, addr, wdata} = '0;
    repeat (12) @(posedge sys_clk);
    arst_n <= 1'b1;
    // Reset values, then an unmapped address.
    rd_reg(OFF_OPTION, v);
    chk("option", v, 32'h4);
    rd_reg(OFF_STATUS, v);
    chk("status", v, 32'h0);
    rd_reg(4'h2, v);
    chk("unmapped", v, 32'h0);
    // Timer mode: write, two stalled cycles, then one step per cycle.
    seed = lfsr(seed);
    n = {1'b0, seed[6:0]};
    wr_reg(OFF_COUNT, {24'h0, n});
    addr <= OFF_COUNT;
    rd <= 1'b1;
    for (k = 0; k < 5; k++) begin
      @(posedge sys_clk);
      if (k == 4) rd <= 1'b0;
      #1 chk("count", rdata, n + (k >= 3 ? k - 2 : 0));
    end
    // Wrap with interrupt enabled.
    wr_reg(OFF_MASK, 32'h1);
    rd_reg(OFF_MASK, v);
    chk("mask", v, 32'h1);
    wr_reg(OFF_COUNT, 32'hFD);
    for (i = 0; i < 20; i++) begin
      @(posedge sys_clk);
      #1 if (gate === 1'b1) break;
    end
    chk("wrap_cycle", i, 4);
    chk("irq", irq, 1'b1);
    rd_reg(OFF_STATUS, v);
    chk("flag", v, 32'h1);
    wr_reg(OFF_STATUS, 32'h1);
    #1 chk("irq_clr", irq, 1'b0);
    chk("gates", ext_m.gate_cnt, 1);
    // Counter mode, rising then falling edge.
    for (k = 0; k < 2; k++) begin
      wr_reg(OFF_OPTION, 32'h5 | (k << 1));
      wr_reg(OFF_COUNT, 32'h0);
      ext_m.toggle(6);
      repeat (4) @(posedge sys_clk);
      rd_reg(OFF_COUNT, v);
      chk("edges", v, 32'h3);
    end
    // Prescaled counter mode, ratios 1:2, 1:4, 1:8.
    for (k = 0; k < 3; k++) begin
      wr_reg(OFF_OPTION, 32'h1 | (k << OPT_PS_LSB));
      wr_reg(OFF_COUNT, 32'h0);
      ext_m.toggle(4 << (k + 1));
      repeat (4) @(posedge sys_clk);
      rd_reg(OFF_COUNT, v);
      chk("presc", v, 32'h2);
    end
    finish_test();
  end
endmodule

/* rtl/tz_prescaler.sv */
// Dedicated prescaler that divides the count source ticks.
`timescale 1ns/1ps
module tz_prescaler #(
  parameter int PRESC_W = 8
) (
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  tz_presc_if.presc pif
);
  import tz_pkg::*;

  typedef struct packed {
    logic [PRESC_W-1:0] cnt;
    logic tick;
  } tz_presc_state_t;

  tz_presc_state_t st_q;
  tz_presc_state_t st_d;
  logic [PRESC_W-1:0] mask;

  initial begin
    if (PRESC_W < 8) begin
      $error("tz_prescaler: PRESC_W must be at least 8");
    end
  end

  // Ratio is 2 to the power of (ratio_sel + 1): 1:2 up to 1:256.
  always_comb begin
    mask = PRESC_W'((32'd1 << (int'(pif.ratio_sel) + 1)) - 32'd1);
    st_d = st_q;
    if (pif.clear) begin
      st_d.cnt = '0;
      st_d.tick = 1'b0;
    end else if (pif.bypass) begin
      st_d.tick = pif.tick_in;
    end else begin
      st_d.tick = pif.tick_in && ((st_q.cnt & mask) == mask);
      if (pif.tick_in) begin
        st_d.cnt = st_q.cnt + PRESC_W'(1);
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign pif.tick_out = st_q.tick;

  a_presc_ratio: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    pif.tick_out |-> $past(pif.bypass)
      || (($past(st_q.cnt) & $past(mask)) == $past(mask)))
    else $error("prescaler tick before its ratio was reached");
endmodule

/* rtl/tz_timer.sv */
// Eight-bit timer/counter with prescaler, overflow interrupt and gate.
`timescale 1ns/1ps
module tz_timer (
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic [tz_pkg::ADDR_W-1:0] addr_i,
  input wire logic [tz_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [tz_pkg::DATA_W-1:0] rdata_o,
  input wire logic external_count_input_i,
  output logic second_timer_gate_o,
  output logic irq_o
);
  import tz_pkg::*;

  typedef struct packed {
    logic [CNT_W-1:0] timer_zero_count;
    logic [OPT_W-1:0] option;
    logic ovf_flag;
    logic ovf_mask;
    logic [1:0] hold;
    logic ext_prev;
    logic gate;
    logic [DATA_W-1:0] rdata;
  } tz_state_t;

  tz_state_t st_q;
  tz_state_t st_d;
  tz_presc_if pif ();

  logic wr_count;
  logic wr_option;
  logic wr_status;
  logic wr_mask;
  logic count_clock_source_select;
  logic count_edge_select;
  logic ext_rise;
  logic ext_fall;
  logic inc;
  logic wrap;

  // ------------------------------------------------------------------
  // Decode and tick source
  // ------------------------------------------------------------------
  assign wr_count = wr_i && (addr_i == OFF_COUNT);
  assign wr_option = wr_i && (addr_i == OFF_OPTION);
  assign wr_status = wr_i && (addr_i == OFF_STATUS);
  assign wr_mask = wr_i && (addr_i == OFF_MASK);
  assign count_clock_source_select = st_q.option[OPT_CS];
  assign count_edge_select = st_q.option[OPT_SE];
  assign ext_rise = external_count_input_i && !st_q.ext_prev;
  assign ext_fall = !external_count_input_i && st_q.ext_prev;

  // The internal source ticks every instruction cycle, so the edge select
  // only changes anything for the external input.
  always_comb begin
    if (count_clock_source_select) begin
      pif.tick_in = count_edge_select ? ext_fall : ext_rise;
    end else begin
      pif.tick_in = 1'b1;
    end
  end

  // A count write also restarts the prescaler so the new value sees a
  // whole prescale period.
  assign pif.clear = wr_count || wr_option;
  assign pif.bypass = st_q.option[OPT_BYP];
  assign pif.ratio_sel = st_q.option[OPT_PS_LSB +: PS_W];

  tz_prescaler #(
    .PRESC_W(8)
  ) u_presc (
    .sys_clk_i(sys_clk_i),
    .arst_n_i(arst_n_i),
    .pif(pif)
  );

  assign inc = pif.tick_out && (st_q.hold == 2'h0) && !wr_count;
  assign wrap = inc && (st_q.timer_zero_count == COUNT_MAX);

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.ext_prev = external_count_input_i;
    st_d.gate = wrap;
    if (st_q.hold != 2'h0) begin
      st_d.hold = st_q.hold - 2'h1;
    end
    if (wr_count) begin
      st_d.timer_zero_count = wdata_i[CNT_W-1:0];
      st_d.hold = WR_HOLD_CYC;
    end else if (inc) begin
      st_d.timer_zero_count = st_q.timer_zero_count + CNT_W'(1);
    end
    if (wr_option) begin
      st_d.option = wdata_i[OPT_W-1:0];
    end
    if (wr_mask) begin
      st_d.ovf_mask = wdata_i[ST_OVF];
    end
    // Set wins over a write-one clear in the same cycle.
    st_d.ovf_flag = wrap
      || (st_q.ovf_flag && !(wr_status && wdata_i[ST_OVF]));
    st_d.rdata = '0;
    if (rd_i) begin
      unique case (addr_i)
        OFF_COUNT: st_d.rdata = DATA_W'(st_q.timer_zero_count);
        OFF_OPTION: st_d.rdata = DATA_W'(st_q.option);
        OFF_STATUS: st_d.rdata = DATA_W'(st_q.ovf_flag);
        OFF_MASK: st_d.rdata = DATA_W'(st_q.ovf_mask);
        default: st_d.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_q.timer_zero_count <= COUNT_RST;
      st_q.option <= OPTION_RST;
      st_q.ovf_flag <= 1'b0;
      st_q.ovf_mask <= 1'b0;
      st_q.hold <= 2'h0;
      st_q.ext_prev <= 1'b0;
      st_q.gate <= 1'b0;
      st_q.rdata <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign rdata_o = st_q.rdata;
  assign second_timer_gate_o = st_q.gate;
  assign irq_o = st_q.ovf_flag && st_q.ovf_mask;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!arst_n_i);

  sequence s_count_write;
    wr_count;
  endsequence

  sequence s_quiet_hold;
    (!wr_count) [*2];
  endsequence

  a_count_write: assert property (s_count_write |=>
    st_q.timer_zero_count == $past(wdata_i[CNT_W-1:0]))
    else $error("count did not take the written value");

  a_count_read: assert property (rd_i && addr_i == OFF_COUNT |=>
    rdata_o == DATA_W'($past(st_q.timer_zero_count)))
    else $error("count read returned wrong data");

  a_write_hold: assert property (s_count_write ##1 s_quiet_hold |=>
    st_q.timer_zero_count == $past(st_q.timer_zero_count, 2))
    else $error("count moved during the post-write stall");

  a_timer_tick: assert property (!count_clock_source_select
    && pif.bypass && !pif.clear |=> pif.tick_out)
    else $error("timer mode missed an instruction cycle tick");

  a_count_step: assert property (pif.tick_out && st_q.hold == 2'h0
    && !wr_count |=> st_q.timer_zero_count
      == $past(st_q.timer_zero_count) + CNT_W'(1))
    else $error("count did not advance on a tick");

  a_ext_edge: assert property (count_clock_source_select && pif.bypass
    && !pif.clear && (count_edge_select ? ext_fall : ext_rise)
    |=> pif.tick_out)
    else $error("selected external edge was not counted");

  a_wrong_edge: assert property (count_clock_source_select && pif.bypass
    && !(count_edge_select ? ext_fall : ext_rise) |=> !pif.tick_out)
    else $error("unselected external edge was counted");

  a_ovf_wrap: assert property (wrap |=>
    st_q.ovf_flag && st_q.timer_zero_count == COUNT_RST)
    else $error("rollover did not wrap and flag");

  a_ovf_sticky: assert property (st_q.ovf_flag
    && !(wr_status && wdata_i[ST_OVF]) |=> st_q.ovf_flag)
    else $error("overflow flag dropped without a clear");

  a_gate_pulse: assert property (second_timer_gate_o |->
    $past(pif.tick_out) && $past(st_q.timer_zero_count) == COUNT_MAX)
    else $error("gate pulse without a rollover");

  // ------------------------------------------------------------------
  // Register bus checks
  // ------------------------------------------------------------------
  // Read data stand for one cycle only, so an idle bus must read zero.
  a_rdata_idle: assert property (!rd_i |=> rdata_o == '0)
    else $error("read data present without a read");

  a_upper_zero: assert property (rd_i |=>
    rdata_o[DATA_W-1:CNT_W] == '0)
    else $error("upper read data bits not zero");

  a_unmapped_read: assert property (rd_i && addr_i[1:0] != 2'h0 |=>
    rdata_o == '0)
    else $error("unmapped read returned data");

  a_option_write: assert property (wr_option |=>
    st_q.option == $past(wdata_i[OPT_W-1:0]))
    else $error("option did not take the written value");

  a_option_read: assert property (rd_i && addr_i == OFF_OPTION |=>
    rdata_o == DATA_W'($past(st_q.option)))
    else $error("option read returned wrong data");

  a_option_keep: assert property (!wr_option |=>
    st_q.option == $past(st_q.option))
    else $error("option changed without a write");

  a_status_read: assert property (rd_i && addr_i == OFF_STATUS |=>
    rdata_o == DATA_W'($past(st_q.ovf_flag)))
    else $error("status read returned wrong data");

  a_mask_write: assert property (wr_mask |=>
    st_q.ovf_mask == $past(wdata_i[ST_OVF]))
    else $error("mask did not take the written value");

  a_mask_read: assert property (rd_i && addr_i == OFF_MASK |=>
    rdata_o == DATA_W'($past(st_q.ovf_mask)))
    else $error("mask read returned wrong data");

  a_mask_keep: assert property (!wr_mask |=>
    st_q.ovf_mask == $past(st_q.ovf_mask))
    else $error("mask changed without a write");

  // ------------------------------------------------------------------
  // Count and stall checks
  // ------------------------------------------------------------------
  // The stall counter is loaded by a count write and then runs down to zero.
  sequence s_stall_entry;
    s_count_write ##1 (!wr_count && st_q.hold == WR_HOLD_CYC);
  endsequence

  a_stall_entry: assert property (s_stall_entry |=>
    st_q.hold == 2'h1)
    else $error("stall did not run down after a write");

  a_hold_load: assert property (wr_count |=>
    st_q.hold == WR_HOLD_CYC)
    else $error("count write did not start the stall");

  a_hold_two: assert property (st_q.hold == 2'h2 && !wr_count |=>
    st_q.hold == 2'h1)
    else $error("stall skipped its second cycle");

  a_hold_one: assert property (st_q.hold == 2'h1 && !wr_count |=>
    st_q.hold == 2'h0)
    else $error("stall lasted too long");

  a_hold_block: assert property (st_q.hold != 2'h0 |-> !inc)
    else $error("count stepped during the stall");

  a_write_no_inc: assert property (wr_count |-> !inc)
    else $error("count stepped in its write cycle");

  a_count_keep: assert property (!wr_count && !inc |=>
    st_q.timer_zero_count == $past(st_q.timer_zero_count))
    else $error("count changed without a tick or write");

  a_count_single: assert property (!wr_count |=>
    st_q.timer_zero_count - $past(st_q.timer_zero_count) <= CNT_W'(1))
    else $error("count moved by more than one");

  // ------------------------------------------------------------------
  // Tick source checks
  // ------------------------------------------------------------------
  a_timer_src: assert property (!count_clock_source_select |->
    pif.tick_in)
    else $error("timer mode source did not tick");

  a_src_rise: assert property (count_clock_source_select
    && !count_edge_select |-> pif.tick_in == ext_rise)
    else $error("rising edge source mismatch");

  a_src_fall: assert property (count_clock_source_select
    && count_edge_select |-> pif.tick_in == ext_fall)
    else $error("falling edge source mismatch");

  a_ext_quiet: assert property (count_clock_source_select
    && !ext_rise && !ext_fall && !pif.clear |=> !pif.tick_out)
    else $error("counter mode ticked without an edge");

  a_bypass_follow: assert property (pif.bypass && !pif.clear |=>
    pif.tick_out == $past(pif.tick_in))
    else $error("bypassed prescaler did not pass the tick");

  a_no_src_tick: assert property (!pif.tick_in |=> !pif.tick_out)
    else $error("prescaler ticked without a source tick");

  a_presc_clear: assert property (pif.clear |=> !pif.tick_out)
    else $error("prescaler ticked right after a clear");

  // ------------------------------------------------------------------
  // Overflow, interrupt and gate checks
  // ------------------------------------------------------------------
  a_flag_clear: assert property (st_q.ovf_flag && wr_status
    && wdata_i[ST_OVF] && !wrap |=> !st_q.ovf_flag)
    else $error("overflow flag ignored a clear");

  a_flag_set_wins: assert property (wrap && wr_status
    && wdata_i[ST_OVF] |=> st_q.ovf_flag)
    else $error("clear beat a same cycle rollover");

  a_flag_quiet: assert property (!st_q.ovf_flag && !wrap |=>
    !st_q.ovf_flag)
    else $error("overflow flag set without a rollover");

  a_irq_mask: assert property (!st_q.ovf_mask |-> !irq_o)
    else $error("masked overflow raised the interrupt");

  a_irq_flag: assert property (st_q.ovf_flag && st_q.ovf_mask |->
    irq_o)
    else $error("unmasked overflow did not interrupt");

  a_gate_follow: assert property (wrap |=> second_timer_gate_o)
    else $error("rollover gave no gate pulse");

  a_gate_single: assert property (second_timer_gate_o |=>
    !second_timer_gate_o)
    else $error("gate pulse longer than one cycle");
endmodule
